// file: shared/rftss_consts.vh
// Constants for the RF trigger, sync and sequencing block
`ifndef RFTSS_CONSTS_VH
`define RFTSS_CONSTS_VH
`define RFTSS_CLK_HZ 125000000
`define RFTSS_CLK_NS 8
`define RFTSS_TRIG_HZ_MIN 2
`define RFTSS_TRIG_HZ_MAX 1000000
`define RFTSS_TRIG_HZ_STEP 1
`define RFTSS_SYNC_DLY_MAX_NS 6553500
`define RFTSS_SYNC_DLY_STEP_NS 100
`define RFTSS_EXPO_RST 32'h00000064
`define RFTSS_READ_RST 32'h00000064
`define RFTSS_DECAY_RST 32'h00000064
`define RFTSS_FRAMES_MIN 2
`define RFTSS_FRAMES_MAX 1023
`define RFTSS_PULSE_CYC 8
`define RFTSS_ADDR_CTRL 4'h0
`define RFTSS_ADDR_FREQ 4'h1
`define RFTSS_ADDR_SDLY 4'h2
`define RFTSS_ADDR_FRAMES 4'h3
`define RFTSS_ADDR_EXPO 4'h4
`define RFTSS_ADDR_READ 4'h5
`define RFTSS_ADDR_DECAY 4'h6
`define RFTSS_ADDR_PTIDX 4'h7
`define RFTSS_ADDR_PTDAT 4'h8
`define RFTSS_ADDR_STAT 4'h9
`define RFTSS_CTRL_SRC 0
`define RFTSS_CTRL_POL 1
`define RFTSS_CTRL_SYNC 2
`define RFTSS_CTRL_RFEN 3
`define RFTSS_CTRL_MODE_LO 4
`define RFTSS_CTRL_MODE_HI 6
`define RFTSS_CTRL_ARM 8
`define RFTSS_MODE_REP 3'h0
`define RFTSS_MODE_SEQ 3'h1
`define RFTSS_MODE_CUST 3'h2
`define RFTSS_MODE_PICO 3'h3
`define RFTSS_MODE_MCP 3'h4
`define RFTSS_FREQ_RST 32'h000003E8
`endif

// file: verilog/rftss_sync_in.v
// Three-stage synchroniser with agreement filter for the trigger pin
`timescale 1ns/10ps
module rftss_sync_in (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Pin and filtered level
  input wire pin_in,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge mclk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted only when the later stages agree
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule

// file: verilog/rftss_rate_gen.v
// Phase accumulator producing one-cycle trigger ticks at a set rate in Hz
`timescale 1ns/10ps
`include "rftss_consts.vh"
module rftss_rate_gen #(
  parameter CLK_HZ = `RFTSS_CLK_HZ
) (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Rate in Hz, already clamped
  input wire [19:0] rate_hz,
  output reg tick_q
);
  reg [27:0] acc_q;
  wire [28:0] sum = {1'b0, acc_q} + {9'h000, rate_hz};
  localparam [28:0] CLK_W = CLK_HZ;
  // Exact average rate: accumulator wraps at CLK_HZ, rate_hz times per second
  always @(posedge mclk) begin
    if (sys_rst) begin
      acc_q <= 28'h0000000;
      tick_q <= 1'b0;
    end else if (sum >= CLK_W) begin
      acc_q <= sum[27:0] - CLK_W[27:0];
      tick_q <= 1'b1;
    end else begin
      acc_q <= sum[27:0];
      tick_q <= 1'b0;
    end
  end
endmodule

// file: verilog/rftss_top.v
// RF trigger, sync output and frame sequencing controller
`timescale 1ns/10ps
`include "rftss_consts.vh"
module rftss_top #(
  parameter RF_CAPABLE = 1,
  parameter PT_DEPTH = 1024,
  parameter PT_AW = 10
) (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // External trigger pin
  input wire ext_trigger_in,
  // Sync outputs
  output reg primary_sync_output_q,
  output reg delayed_sync_output_q,
  // Acquisition outputs
  output reg gate_q,
  output reg rf_on_q,
  output reg image_shift_q,
  output reg [31:0] rf_freq_q,
  output reg [15:0] rf_phase_q,
  output reg busy_q
);
  localparam [31:0] DLY_NS = `RFTSS_SYNC_DLY_STEP_NS;
  localparam [19:0] HZ_MIN = `RFTSS_TRIG_HZ_MIN;
  localparam [19:0] HZ_MAX = `RFTSS_TRIG_HZ_MAX;
  localparam [9:0] FR_MIN = `RFTSS_FRAMES_MIN;
  localparam [9:0] FR_MAX = `RFTSS_FRAMES_MAX;
  localparam [3:0] PW = `RFTSS_PULSE_CYC;
  // One-hot sequencer states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_WAIT = 5'h02;
  localparam [4:0] S_EXPO = 5'h04;
  localparam [4:0] S_DECAY = 5'h08;
  localparam [4:0] S_READ = 5'h10;

  // Settings
  reg src_ext_q;
  reg pol_neg_q;
  reg sync_en_q;
  reg rf_en_q;
  reg [2:0] mode_q;
  reg [19:0] freq_q;
  reg [15:0] sdly_q;
  reg [9:0] frames_q;
  reg [31:0] expo_q;
  reg [31:0] read_q;
  reg [31:0] decay_q;
  reg [PT_AW-1:0] ptidx_q;
  reg mode_err_q;
  reg [47:0] pt_mem [0:PT_DEPTH-1];

  // Sequencer state
  reg [4:0] st_q;
  reg [31:0] cnt_q;
  reg [9:0] frame_q;
  reg [PT_AW-1:0] pt_q;
  reg arm_q;

  function [19:0] clamp_hz;
    input [31:0] v;
    begin
      if (v < {12'h000, HZ_MIN}) begin
        clamp_hz = HZ_MIN;
      end else if (v > {12'h000, HZ_MAX}) begin
        clamp_hz = HZ_MAX;
      end else begin
        clamp_hz = v[19:0];
      end
    end
  endfunction

  function [9:0] clamp_fr;
    input [31:0] v;
    begin
      if (v < {22'h000000, FR_MIN}) begin
        clamp_fr = FR_MIN;
      end else if (v > {22'h000000, FR_MAX}) begin
        clamp_fr = FR_MAX;
      end else begin
        clamp_fr = v[9:0];
      end
    end
  endfunction

  wire wr_ctrl = reg_wr && (reg_addr == `RFTSS_ADDR_CTRL);
  wire [2:0] wmode = reg_wdata[`RFTSS_CTRL_MODE_HI:`RFTSS_CTRL_MODE_LO];
  wire bad_mode = (wmode != `RFTSS_MODE_REP) && (wmode != `RFTSS_MODE_SEQ) &&
    (wmode != `RFTSS_MODE_CUST);

  // Register writes
  always @(posedge mclk) begin
    if (sys_rst) begin
      src_ext_q <= 1'b0;
      pol_neg_q <= 1'b0;
      sync_en_q <= 1'b0;
      rf_en_q <= 1'b0;
      mode_q <= `RFTSS_MODE_REP;
      mode_err_q <= 1'b0;
      freq_q <= clamp_hz(`RFTSS_FREQ_RST);
      sdly_q <= 16'h0000;
      frames_q <= FR_MIN;
      expo_q <= `RFTSS_EXPO_RST;
      read_q <= `RFTSS_READ_RST;
      decay_q <= `RFTSS_DECAY_RST;
      ptidx_q <= {PT_AW{1'b0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `RFTSS_ADDR_CTRL: begin
          src_ext_q <= reg_wdata[`RFTSS_CTRL_SRC];
          pol_neg_q <= reg_wdata[`RFTSS_CTRL_POL];
          sync_en_q <= reg_wdata[`RFTSS_CTRL_SYNC];
          rf_en_q <= reg_wdata[`RFTSS_CTRL_RFEN];
          // Reject, keep previous mode, flag error
          if (bad_mode) begin
            mode_err_q <= 1'b1;
          end else begin
            mode_q <= wmode;
            mode_err_q <= 1'b0;
          end
        end
        `RFTSS_ADDR_FREQ: freq_q <= clamp_hz(reg_wdata);
        `RFTSS_ADDR_SDLY: sdly_q <= reg_wdata[15:0];
        `RFTSS_ADDR_FRAMES: frames_q <= clamp_fr(reg_wdata);
        `RFTSS_ADDR_EXPO: expo_q <= reg_wdata;
        `RFTSS_ADDR_READ: read_q <= reg_wdata;
        `RFTSS_ADDR_DECAY: decay_q <= reg_wdata;
        `RFTSS_ADDR_PTIDX: ptidx_q <= reg_wdata[PT_AW-1:0];
        `RFTSS_ADDR_PTDAT: ptidx_q <= ptidx_q + {{(PT_AW-1){1'b0}}, 1'b1};
        default: ptidx_q <= ptidx_q;
      endcase
    end
  end

  // Point table, word holds frequency and phase
  always @(posedge mclk) begin
    if (reg_wr && (reg_addr == `RFTSS_ADDR_PTDAT)) begin
      pt_mem[ptidx_q] <= {reg_wdata, 16'h0000} | {32'h00000000, reg_wdata[31:16]};
    end
  end

  // Internal trigger and external trigger conditioning
  wire int_tick;
  wire ext_lvl;
  reg ext_prev_q;
  rftss_rate_gen u_rate (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .rate_hz(freq_q),
    .tick_q(int_tick)
  );
  rftss_sync_in u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(ext_trigger_in),
    .level_q(ext_lvl)
  );
  always @(posedge mclk) begin
    if (sys_rst) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_lvl;
    end
  end
  wire ext_tick = pol_neg_q ? (ext_prev_q & ~ext_lvl) : (~ext_prev_q & ext_lvl);
  wire trig = src_ext_q ? ext_tick : int_tick;

  // Sync outputs
  reg [3:0] p_w_q;
  reg [3:0] d_w_q;
  reg d_pend_q;
  reg d_run_q;
  reg d_fire_q;
  reg [31:0] d_cnt_q;
  wire d_tick;
  // Whole clocks; odd step counts lose 4 ns to the 8 ns clock
  wire [31:0] d_cyc = ({16'h0000, sdly_q} * DLY_NS) / `RFTSS_CLK_NS;
  wire d_zero = d_pend_q && (d_cnt_q == 32'h00000000);
  wire d_realign = reg_wr && ((reg_addr == `RFTSS_ADDR_FREQ) || (reg_addr == `RFTSS_ADDR_SDLY));
  // Twin accumulator restarted by the first delayed pulse; survives delays over a period
  wire d_gen_rst = sys_rst || !d_run_q;
  rftss_rate_gen u_drate (
    .mclk(mclk),
    .sys_rst(d_gen_rst),
    .rate_hz(freq_q),
    .tick_q(d_tick)
  );
  always @(posedge mclk) begin
    if (sys_rst) begin
      p_w_q <= 4'h0;
      d_w_q <= 4'h0;
      d_pend_q <= 1'b0;
      d_run_q <= 1'b0;
      d_fire_q <= 1'b0;
      d_cnt_q <= 32'h00000000;
      primary_sync_output_q <= 1'b0;
      delayed_sync_output_q <= 1'b0;
    end else begin
      // Primary pulse on each internal tick, always full width
      if (sync_en_q && int_tick) begin
        p_w_q <= PW;
      end else if (p_w_q != 4'h0) begin
        p_w_q <= p_w_q - 4'h1;
      end
      primary_sync_output_q <= (sync_en_q && int_tick) || (p_w_q > 4'h1);
      // First tick starts the delay; a rate or delay write realigns
      if (!sync_en_q || d_realign) begin
        d_pend_q <= 1'b0;
        d_run_q <= 1'b0;
      end else if (int_tick && !d_pend_q && !d_run_q) begin
        d_pend_q <= 1'b1;
        d_cnt_q <= d_cyc;
      end else if (d_zero) begin
        d_pend_q <= 1'b0;
        d_run_q <= 1'b1;
      end else if (d_pend_q) begin
        d_cnt_q <= d_cnt_q - 32'h00000001;
      end
      d_fire_q <= d_zero && sync_en_q && !d_realign;
      if (d_fire_q || (d_run_q && d_tick)) begin
        d_w_q <= PW;
      end else if (d_w_q != 4'h0) begin
        d_w_q <= d_w_q - 4'h1;
      end
      delayed_sync_output_q <= (d_w_q != 4'h0);
    end
  end

  // RF gated by capability and enable
  wire rf_allowed = (RF_CAPABLE != 0) && rf_en_q;
  wire [9:0] n_frames = (mode_q == `RFTSS_MODE_REP) ? 10'h001 : frames_q;
  wire [47:0] pt_word = pt_mem[pt_q];
  wire last_frame = (frame_q + 10'h001) >= n_frames;

  // Frame sequencer
  always @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      cnt_q <= 32'h00000000;
      frame_q <= 10'h000;
      pt_q <= {PT_AW{1'b0}};
      arm_q <= 1'b0;
      gate_q <= 1'b0;
      rf_on_q <= 1'b0;
      image_shift_q <= 1'b0;
      rf_freq_q <= 32'h00000000;
      rf_phase_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      image_shift_q <= 1'b0;
      arm_q <= wr_ctrl && reg_wdata[`RFTSS_CTRL_ARM];
      case (st_q)
        S_IDLE: begin
          if (arm_q) begin
            frame_q <= 10'h000;
            pt_q <= {PT_AW{1'b0}};
            busy_q <= 1'b1;
            st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Same frequency to both, phase of this image
          rf_freq_q <= pt_word[47:16];
          rf_phase_q <= pt_word[15:0];
          if (trig) begin
            gate_q <= 1'b1;
            rf_on_q <= rf_allowed;
            cnt_q <= expo_q;
            st_q <= S_EXPO;
          end
        end
        S_EXPO: begin
          if (cnt_q == 32'h00000000) begin
            gate_q <= 1'b0;
            rf_on_q <= 1'b0;
            cnt_q <= decay_q;
            st_q <= S_DECAY;
          end else begin
            cnt_q <= cnt_q - 32'h00000001;
          end
        end
        S_DECAY: begin
          if (cnt_q == 32'h00000000) begin
            image_shift_q <= 1'b1;
            cnt_q <= read_q;
            st_q <= S_READ;
          end else begin
            cnt_q <= cnt_q - 32'h00000001;
          end
        end
        S_READ: begin
          if (cnt_q != 32'h00000000) begin
            cnt_q <= cnt_q - 32'h00000001;
          end else if (last_frame) begin
            busy_q <= 1'b0;
            st_q <= S_IDLE;
          end else begin
            // One point per frame, stored order
            frame_q <= frame_q + 10'h001;
            pt_q <= pt_q + {{(PT_AW-1){1'b0}}, 1'b1};
            st_q <= S_WAIT;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RFTSS_ADDR_CTRL: reg_rdata_q <= {23'h000000, 2'h0, mode_q, rf_en_q,
          sync_en_q, pol_neg_q, src_ext_q};
        `RFTSS_ADDR_FREQ: reg_rdata_q <= {12'h000, freq_q};
        `RFTSS_ADDR_SDLY: reg_rdata_q <= {16'h0000, sdly_q};
        `RFTSS_ADDR_FRAMES: reg_rdata_q <= {22'h000000, frames_q};
        `RFTSS_ADDR_EXPO: reg_rdata_q <= expo_q;
        `RFTSS_ADDR_READ: reg_rdata_q <= read_q;
        `RFTSS_ADDR_DECAY: reg_rdata_q <= decay_q;
        `RFTSS_ADDR_PTIDX: reg_rdata_q <= {{(32-PT_AW){1'b0}}, ptidx_q};
        `RFTSS_ADDR_STAT: reg_rdata_q <= {9'h000, mode_err_q, 2'h0, frame_q,
          3'h0, st_q, 1'h0, ext_lvl};
        default: reg_rdata_q <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end
endmodule

// file: tb/rftss_top_assertions.sv
// Port-level assertions for the RF trigger and sequencing block
`timescale 1ns/10ps
module rftss_chk (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Register port
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  // Sync outputs
  input wire primary_sync_output_q,
  input wire delayed_sync_output_q,
  // Acquisition outputs
  input wire gate_q,
  input wire rf_on_q,
  input wire image_shift_q,
  input wire [31:0] rf_freq_q,
  input wire [15:0] rf_phase_q,
  input wire busy_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data not zero outside answer cycle");
  chk_sync_width: assert property (
    $rose(primary_sync_output_q) |-> primary_sync_output_q [*8] ##1 !primary_sync_output_q)
    else $error("primary sync pulse width wrong");
  chk_sync_gap: assert property (
    $fell(primary_sync_output_q) |-> !primary_sync_output_q [*8])
    else $error("primary sync pulses too close");
  chk_dsync_width: assert property (
    $rose(delayed_sync_output_q) |-> delayed_sync_output_q [*8] ##1 !delayed_sync_output_q)
    else $error("delayed sync pulse width wrong");
  chk_rf_in_gate: assert property (
    rf_on_q |-> gate_q)
    else $error("rf on outside exposure");
  chk_gate_busy: assert property (
    gate_q |-> busy_q)
    else $error("exposure outside a running sequence");
  chk_shift_after_gate: assert property (
    image_shift_q |-> !gate_q && $past(gate_q) == 1'b0)
    else $error("image shift during or right after exposure");
  chk_shift_single: assert property (
    image_shift_q |=> !image_shift_q)
    else $error("image shift longer than one cycle");
  chk_point_hold: assert property (
    gate_q && $past(gate_q) |-> $stable(rf_freq_q) && $stable(rf_phase_q))
    else $error("point changed during exposure");
endmodule

bind rftss_top rftss_chk CHK (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q),
  .primary_sync_output_q(primary_sync_output_q),
  .delayed_sync_output_q(delayed_sync_output_q),
  .gate_q(gate_q),
  .rf_on_q(rf_on_q),
  .image_shift_q(image_shift_q),
  .rf_freq_q(rf_freq_q),
  .rf_phase_q(rf_phase_q),
  .busy_q(busy_q)
);

// file: tb/rftss_trig_src.sv
// External trigger source model driving the rear trigger pin
`timescale 1ns/10ps
module rftss_trig_src (
  // Clock
  input wire logic mclk,
  // Trigger pin, push-pull so it never floats
  output logic trig_out
);
  initial trig_out = 1'b0;
  task automatic drive(input logic v);
    @(posedge mclk);
    trig_out <= v;
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the RF trigger and sequencing block
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [31:0] reg_rdata_q;
  wire ext_trig;
  wire pri, dly, gate, rf_on, shift, busy;
  wire [31:0] rf_freq;
  wire [15:0] rf_phase;
  wire [4:0] obs = {busy, shift, gate, dly, pri};
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  logic [31:0] d;
  // Deliberately neither ascending nor descending
  logic [31:0] pts [3] = '{32'h12345678, 32'h000000A0, 32'h7FFF0001};

  rftss_top DUT (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .ext_trigger_in(ext_trig),
    .primary_sync_output_q(pri),
    .delayed_sync_output_q(dly),
    .gate_q(gate),
    .rf_on_q(rf_on),
    .image_shift_q(shift),
    .rf_freq_q(rf_freq),
    .rf_phase_q(rf_phase),
    .busy_q(busy)
  );
  rftss_trig_src PART (
    .mclk(mclk),
    .trig_out(ext_trig)
  );

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
  endtask
  // Bounded wait for a level; returns lim when it never came
  task automatic lvl(input int i, input logic v, input int lim, output int c);
    c = 0;
    while (obs[i] !== v && c < lim) begin
      @(posedge mclk);
      #1 c++;
    end
  endtask
  task automatic rise(input int i, input int lim, output int c);
    int k;
    lvl(i, 1'b0, lim, k);
    lvl(i, 1'b1, lim, c);
    c += k;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_regs();
    rd(4'h1, d);
    chk("freq rst", d, 32'h3E8);
    wr(4'h1, 32'h1);
    rd(4'h1, d);
    chk("freq low", d, 32'h2);
    wr(4'h1, 32'h1E8481);
    rd(4'h1, d);
    chk("freq high", d, 32'hF4240);
    wr(4'h3, 32'h1);
    rd(4'h3, d);
    chk("frames low", d, 32'h2);
    wr(4'h3, 32'h400);
    rd(4'h3, d);
    chk("frames high", d, 32'h3FF);
    rd(4'h6, d);
    chk("decay rst", d, 32'h64);
    rd(4'hF, d);
    chk("unmapped", d, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 5; m++) begin
      wr(4'h0, m << 4);
      rd(4'h0, d);
      chk("mode", d[6:4], (m < 3) ? m : 2);
      rd(4'h9, d);
      chk("mode err", d[22], m > 2);
    end
    $display("t_modes done");
  endtask
  task automatic t_sync();
    int p;
    wr(4'h1, 32'hF4240);
    wr(4'h2, 32'h2);
    wr(4'h0, 32'h4);
    rise(0, 400, n);
    rise(0, 400, n);
    chk("sync period", n, 125);
    rise(1, 400, n);
    // Pipeline adds a few cycles to the coarse step
    chk("sync delay", (n >= 24 && n <= 29), 1'b1);
    p = n - 25;
    rise(1, 400, n);
    chk("dsync period", n, 125);
    // 2000 ns is two whole periods, so only the same pipeline offset remains
    wr(4'h2, 32'h14);
    repeat (3) rise(0, 400, n);
    rise(1, 400, n);
    chk("long delay", n, p);
    wr(4'h0, 32'h0);
    // Let pulses already running finish
    repeat (10) @(posedge mclk);
    rise(0, 300, n);
    chk("sync off", n, 300);
    rise(1, 300, n);
    chk("dsync off", n, 300);
    $display("t_sync done");
  endtask
  task automatic t_seq();
    wr(4'h4, 32'h9);
    wr(4'h5, 32'h9);
    wr(4'h6, 32'h13);
    wr(4'h3, 32'h3);
    wr(4'h7, 32'h0);
    for (int k = 0; k < 3; k++)
      wr(4'h8, pts[k]);
    wr(4'h0, 32'h118);
    for (int k = 0; k < 3; k++) begin
      rise(2, 400, n);
      chk("freq", rf_freq, pts[k]);
      chk("phase", rf_phase, pts[k][31:16]);
      chk("rf on", rf_on, 1'b1);
      lvl(2, 1'b0, 400, n);
      chk("expo", n, 10);
      lvl(3, 1'b1, 400, n);
      chk("decay", (n >= 20 && n <= 23), 1'b1);
      chk("rf off", rf_on, 1'b0);
    end
    lvl(4, 1'b0, 400, n);
    chk("done", (n < 400), 1'b1);
    lvl(2, 1'b1, 300, n);
    chk("no extra", n, 300);
    $display("t_seq done");
  endtask
  task automatic t_ext();
    for (int p = 0; p < 2; p++) begin
      PART.drive(p[0]);
      repeat (8) @(posedge mclk);
      wr(4'h0, 32'h101 | (p << 1));
      rd(4'h9, d);
      chk("ext lvl", d[0], p[0]);
      // Internal ticks keep running but must be ignored
      lvl(2, 1'b1, 300, n);
      chk("ext idle", n, 300);
      PART.drive(~p[0]);
      lvl(2, 1'b1, 40, n);
      chk("ext gate", (n < 40), 1'b1);
      chk("rf disabled", rf_on, 1'b0);
      PART.drive(p[0]);
      lvl(4, 1'b0, 400, n);
    end
    $display("t_ext done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_modes();
    t_sync();
    t_seq();
    t_ext();
    summarize();
  end
  // Tests need under 10k cycles; allow 50k
  initial begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    summarize();
  end
endmodule
